// ---- hdl/twt_cond.sv ----
// Line synchroniser and start, stop and idle condition detector.
`timescale 1ns/1ps
`default_nettype none
module twt_cond (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   // Conditions to the target logic.
   twt_cond_if.src cond
);
   import twt_pkg::*;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_s3;
      logic sda_s1;
      logic sda_s2;
      logic sda_s3;
   } twt_cond_st_t;

   twt_cond_st_t cur_ff;
   twt_cond_st_t nxt_cur;

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.scl_s1 = scl_in;
      nxt_cur.scl_s2 = cur_ff.scl_s1;
      nxt_cur.scl_s3 = cur_ff.scl_s2;
      nxt_cur.sda_s1 = sda_in;
      nxt_cur.sda_s2 = cur_ff.sda_s1;
      nxt_cur.sda_s3 = cur_ff.sda_s2;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur_ff <= '{LINE_RST, LINE_RST, LINE_RST, LINE_RST, LINE_RST, LINE_RST};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ---------------------------------------------------------------
   // Conditions, judged only from the second and third stages.
   // ---------------------------------------------------------------
   assign cond.scl = cur_ff.scl_s2;
   assign cond.sda = cur_ff.sda_s2;
   assign cond.scl_rise = cur_ff.scl_s2 & ~cur_ff.scl_s3;
   assign cond.scl_fall = ~cur_ff.scl_s2 & cur_ff.scl_s3;
   // A data change while the clock stays high is a condition, never a bit. [RULE5]
   assign cond.start = cur_ff.scl_s2 & cur_ff.scl_s3 & cur_ff.sda_s3 & ~cur_ff.sda_s2; // [RULE7]
   assign cond.stop = cur_ff.scl_s2 & cur_ff.scl_s3 & ~cur_ff.sda_s3 & cur_ff.sda_s2; // [RULE9]
   assign cond.idle = cur_ff.scl_s2 & cur_ff.sda_s2; // [RULE6]

endmodule // twt_cond
`default_nettype wire

// ---- hdl/twt_target.sv ----
// Two-wire bus target front end: conditions, bit framing, acknowledge and write timer.
//
// Operation
// RULE1: The controller makes the clock, owns the bus, and makes starts and stops.
// RULE2: The controller picks transfer direction; the target follows the read/write bit.
// RULE3: The controller begins a transfer only while the bus is idle.
// RULE4: The driving party keeps the data line steady while the clock is high.
// RULE5: A data change with the clock high is a start or stop, never data.
// RULE6: The bus is idle while both data and clock lines are high.
// RULE7: Data falling while the clock is high is a start condition.
// RULE8: The controller issues a start before every command.
// RULE9: Data rising while the clock is high is a stop condition.
// RULE10: The controller ends every operation with a stop condition.
// RULE11: Driven data changes only after a hold delay of 300 ns past clock fall.
// RULE12: The self-timed write cycle finishes within 5 ms.
// RULE13: Data changes only while the clock is low; one clock pulse per bit.
// RULE14: The receiver acknowledges every byte in an extra controller clock pulse. The target acknowledges a received byte only while ack_en is high.
// RULE15: No acknowledge is given while the write cycle runs.
// RULE16: Start abandons the transfer; stop releases the data line and returns idle.
`timescale 1ns/1ps
`default_nettype none
module twt_target #(
   parameter int unsigned WRC_CYCLES = twt_pkg::WRC_CYC
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Receive side.
   input wire logic ack_en,
   output logic [7:0] rx_data,
   output logic rx_valid,
   // Transmit side.
   input wire logic [7:0] tx_data,
   output logic tx_req,
   output logic host_nack,
   // Bus status.
   output logic start_seen,
   output logic stop_seen,
   output logic bus_idle,
   output logic dir_read,
   // Internal write cycle.
   input wire logic wr_req,
   output logic wr_busy
);
   import twt_pkg::*;

   typedef struct packed {
      twt_state_t state;
      logic [BIT_W-1:0] bit_cnt;
      logic [7:0] shift;
      logic first;
      logic full;
      logic rd;
      logic [HOLD_W-1:0] hold;
      logic oe_n;
      logic [WRC_W-1:0] wrc;
      logic [7:0] rx_byte;
      logic rx_pulse;
      logic tx_pulse;
      logic nack_pulse;
      logic start_pulse;
      logic stop_pulse;
   } twt_st_t;

   localparam twt_st_t ST_RST = '{TWT_IDLE, BIT_RST, BYTE_RST, 1'b0, 1'b0, 1'b0, HOLD_RST,
                                  LINE_RST, WRC_RST, BYTE_RST, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC);
   localparam logic [WRC_W-1:0] WRC_LOAD = WRC_W'(WRC_CYCLES);

   twt_cond_if cond ();

   twt_cond u_cond (
      .clock(clock),
      .rst(rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .cond(cond)
   );

   twt_st_t cur_ff;
   twt_st_t nxt_cur;
   logic want_oe_n;
   logic busy;

   assign busy = (cur_ff.wrc != WRC_RST);

   // ---------------------------------------------------------------
   // Level the target wants on the data line in its present state.
   // ---------------------------------------------------------------
   always_comb begin
      unique case (cur_ff.state)
         TWT_ACK_OUT: want_oe_n = 1'b0;
         TWT_SEND: want_oe_n = cur_ff.shift[7];
         default: want_oe_n = 1'b1;
      endcase
   end

   // ---------------------------------------------------------------
   // Next state.
   // ---------------------------------------------------------------
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.rx_pulse = 1'b0;
      nxt_cur.tx_pulse = 1'b0;
      nxt_cur.nack_pulse = 1'b0;
      nxt_cur.start_pulse = 1'b0;
      nxt_cur.stop_pulse = 1'b0;

      // Self-timed write cycle, a counted fixed length equal to the limit by default.
      if (busy) begin
         nxt_cur.wrc = cur_ff.wrc - 1'b1; // [RULE12]
      end else if (wr_req) begin
         nxt_cur.wrc = WRC_LOAD; // [RULE12]
      end

      // The pin follows the wanted level only once the hold time has run out.
      if (cur_ff.hold != HOLD_RST) begin
         nxt_cur.hold = cur_ff.hold - 1'b1;
      end else begin
         nxt_cur.oe_n = want_oe_n; // [RULE11] [RULE13] [RULE4]
      end

      if (cond.start) begin
         // A start, even a repeated one, drops whatever was in flight. [RULE16]
         nxt_cur.state = TWT_RECV;
         nxt_cur.bit_cnt = BIT_RST;
         nxt_cur.full = 1'b0;
         nxt_cur.first = 1'b1;
         nxt_cur.rd = 1'b0;
         nxt_cur.oe_n = 1'b1;
         nxt_cur.hold = HOLD_RST;
         nxt_cur.start_pulse = 1'b1; // [RULE7]
      end else if (cond.stop) begin
         nxt_cur.state = TWT_IDLE; // [RULE16]
         nxt_cur.oe_n = 1'b1; // [RULE16]
         nxt_cur.hold = HOLD_RST;
         nxt_cur.rd = 1'b0;
         nxt_cur.stop_pulse = 1'b1; // [RULE9]
      end else begin
         if (cond.scl_fall) begin
            nxt_cur.hold = HOLD_LOAD; // [RULE11]
         end
         unique case (cur_ff.state)
            TWT_IDLE, TWT_WAIT: begin
            end
            TWT_RECV: begin
               // Bits are taken at the clock rise, one per pulse. [RULE13]
               if (cond.scl_rise && !cur_ff.full) begin
                  nxt_cur.shift = {cur_ff.shift[6:0], cond.sda};
                  nxt_cur.bit_cnt = cur_ff.bit_cnt + 1'b1;
                  nxt_cur.full = (cur_ff.bit_cnt == BIT_LAST);
               end else if (cond.scl_fall && cur_ff.full) begin
                  nxt_cur.full = 1'b0;
                  nxt_cur.bit_cnt = BIT_RST;
                  nxt_cur.rx_byte = cur_ff.shift;
                  nxt_cur.rx_pulse = 1'b1;
                  if (ack_en && !busy) begin
                     nxt_cur.state = TWT_ACK_OUT; // [RULE14]
                     if (cur_ff.first) begin
                        nxt_cur.rd = cur_ff.shift[0]; // [RULE2]
                     end
                  end else begin
                     nxt_cur.state = TWT_WAIT; // [RULE15]
                  end
                  nxt_cur.first = 1'b0;
               end
            end
            TWT_ACK_OUT: begin
               if (cond.scl_fall) begin
                  if (cur_ff.rd) begin
                     nxt_cur.state = TWT_SEND; // [RULE2]
                     nxt_cur.shift = tx_data;
                     nxt_cur.bit_cnt = BIT_RST;
                     nxt_cur.tx_pulse = 1'b1;
                  end else begin
                     nxt_cur.state = TWT_RECV;
                  end
               end
            end
            TWT_SEND: begin
               if (cond.scl_fall) begin
                  nxt_cur.shift = {cur_ff.shift[6:0], 1'b1};
                  nxt_cur.bit_cnt = cur_ff.bit_cnt + 1'b1;
                  if (cur_ff.bit_cnt == BIT_LAST) begin
                     nxt_cur.state = TWT_ACK_IN;
                     nxt_cur.full = 1'b0;
                  end
               end
            end
            TWT_ACK_IN: begin
               if (cond.scl_rise) begin
                  nxt_cur.full = ~cond.sda; // [RULE14]
               end else if (cond.scl_fall) begin
                  if (cur_ff.full) begin
                     nxt_cur.state = TWT_SEND;
                     nxt_cur.shift = tx_data;
                     nxt_cur.bit_cnt = BIT_RST;
                     nxt_cur.tx_pulse = 1'b1;
                  end else begin
                     // The controller ends a read by leaving the ack high.
                     nxt_cur.state = TWT_WAIT;
                     nxt_cur.nack_pulse = 1'b1;
                  end
                  nxt_cur.full = 1'b0;
               end
            end
            default: nxt_cur.state = TWT_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur_ff <= ST_RST;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ---------------------------------------------------------------
   // Outputs.
   // ---------------------------------------------------------------
   // The line is open drain: only ever pulled low, released otherwise.
   assign sda_out = 1'b0;
   assign sda_oe_n = cur_ff.oe_n;
   assign rx_data = cur_ff.rx_byte;
   assign rx_valid = cur_ff.rx_pulse;
   assign tx_req = cur_ff.tx_pulse;
   assign host_nack = cur_ff.nack_pulse;
   assign start_seen = cur_ff.start_pulse;
   assign stop_seen = cur_ff.stop_pulse;
   assign bus_idle = cond.idle; // [RULE6]
   assign dir_read = cur_ff.rd;
   assign wr_busy = busy;

endmodule // twt_target
`default_nettype wire

// ---- shared/twt_cond_if.sv ----
// Interface carrying synchronised line levels and bus conditions.
`timescale 1ns/1ps
`default_nettype none
interface twt_cond_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic idle;

   modport src (output scl, output sda, output scl_rise, output scl_fall,
                output start, output stop, output idle);
   modport snk (input scl, input sda, input scl_rise, input scl_fall,
                input start, input stop, input idle);
endinterface
`default_nettype wire

// ---- shared/twt_pkg.sv ----
// Constants and types shared by the two-wire target front end.
package twt_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int HOLD_MIN_NS = 300;
   // Least time rounds up to whole cycles.
   localparam int HOLD_CYC = (HOLD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HOLD_W = 7;
   localparam int WRC_MAX_MS = 5;
   // Longest time rounds down to whole cycles.
   // Cycles per millisecond first, so the product stays inside a 32-bit int.
   localparam int WRC_CYC = WRC_MAX_MS * (1000000000 / CLK_PERIOD_PS);
   localparam int WRC_W = 20;

   // ---------------------------------------------------------------
   // Byte framing and reset values
   // ---------------------------------------------------------------
   localparam int BIT_W = 3;
   localparam logic [BIT_W-1:0] BIT_LAST = 3'h7;
   localparam logic [BIT_W-1:0] BIT_RST = 3'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [HOLD_W-1:0] HOLD_RST = 7'h00;
   localparam logic [WRC_W-1:0] WRC_RST = 20'h00000;
   localparam logic LINE_RST = 1'b1;

   // ---------------------------------------------------------------
   // Target states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      TWT_IDLE = 3'b000,
      TWT_RECV = 3'b001,
      TWT_ACK_OUT = 3'b010,
      TWT_SEND = 3'b011,
      TWT_ACK_IN = 3'b100,
      TWT_WAIT = 3'b101
   } twt_state_t;

endpackage

// ---- test/tb_top.sv ----
// Self-checking bench for the two-wire target front end.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ack_en = 1'b0;
   logic wr_req = 1'b0;
   logic [7:0] tx_data = 8'h00;
   wire scl;
   wire sda_low;
   wire sda;
   logic sda_out, sda_oe_n, rx_valid, tx_req, host_nack, start_seen, stop_seen;
   logic bus_idle, dir_read, wr_busy;
   logic [7:0] rx_data;
   int n_mismatch = 0;
   int num_checks = 0;
   int n_start = 0;
   int n_stop = 0;
   int n_rx = 0;
   int n_nack = 0;
   int n_tx = 0;
   logic ack;
   logic [7:0] d1, d2;
   // Open-drain data line with a pull-up.
   assign sda = (sda_oe_n ? 1'b1 : sda_out) & !sda_low;
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      n_start <= n_start + int'(start_seen === 1'b1);
      n_stop <= n_stop + int'(stop_seen === 1'b1);
      n_rx <= n_rx + int'(rx_valid === 1'b1);
      n_nack <= n_nack + int'(host_nack === 1'b1);
      n_tx <= n_tx + int'(tx_req === 1'b1);
   end
   twt_ctrl_model m (.scl(scl), .sda_low(sda_low), .sda(sda));
   twt_target #(.WRC_CYCLES(2000)) i_dut (.clock(clock), .rst(rst), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ack_en(ack_en),
      .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_req(tx_req),
      .host_nack(host_nack), .start_seen(start_seen), .stop_seen(stop_seen),
      .bus_idle(bus_idle), .dir_read(dir_read), .wr_req(wr_req), .wr_busy(wr_busy));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic t_reset();
      check({sda_out, sda_oe_n, bus_idle, dir_read, wr_busy}, 5'h0c);
      check(rx_data, 8'h00);
   endtask
   task automatic t_write();
      @(negedge clock) ack_en = 1'b1;
      m.start();
      m.wr_byte(8'ha6, ack);
      check({ack, dir_read}, 2'h0);
      check(rx_data, 8'ha6);
      @(negedge clock) ack_en = 1'b0;
      m.wr_byte(8'h81, ack);
      check({ack, rx_data}, 9'h181);
      m.stop();
      check({n_start[3:0], n_stop[3:0], n_rx[3:0]}, 12'h112);
      check({bus_idle, sda_oe_n}, 2'h3);
   endtask
   task automatic t_read();
      @(negedge clock) ack_en = 1'b1;
      tx_data = 8'h5c;
      m.start();
      m.wr_byte(8'ha7, ack);
      check({ack, dir_read}, 2'h1);
      fork
         begin
            m.rd_byte(1'b0, d1);
            m.rd_byte(1'b1, d2);
         end
         begin
            @(posedge tx_req);
            @(negedge clock) tx_data = 8'h3b;
         end
      join
      check({d1, d2}, 16'h5c3b);
      repeat (8) @(negedge clock);
      check({n_start[3:0], n_tx[3:0], n_nack[3:0]}, 12'h221);
      m.stop();
      check({sda_oe_n, dir_read}, 2'h2);
   endtask
   task automatic t_busy();
      int k;
      @(negedge clock) wr_req = 1'b1;
      @(negedge clock) wr_req = 1'b0;
      check(wr_busy, 1'b1);
      m.start();
      m.wr_byte(8'ha6, ack);
      check(ack, 1'b1);
      m.stop();
      k = 0;
      while (wr_busy === 1'b1 && k < 2100) begin
         @(negedge clock);
         k++;
      end
      check(wr_busy, 1'b0);
      m.start();
      m.wr_byte(8'ha6, ack);
      check(ack, 1'b0);
      m.stop();
   endtask
   task automatic t_restart();
      int r0;
      r0 = n_rx;
      m.start();
      for (int i = 0; i < 4; i++) m.pulse(1'b0, ack);
      m.start();
      check(16'(n_rx - r0), 16'h0000);
      m.wr_byte(8'h54, ack);
      check({ack, rx_data}, 9'h054);
      m.stop();
   endtask
   initial begin
      repeat (16) @(posedge clock);
      @(negedge clock) rst = 1'b0;
      repeat (4) @(negedge clock);
      t_reset();
      t_write();
      t_read();
      t_busy();
      t_restart();
      final_report();
   end
   initial begin
      #300000;
      n_mismatch++;
      final_report();
   end
endmodule // tb_top
`default_nettype wire

// ---- test/twt_checker.sv ----
// Concurrent checks on the ports of the two-wire target front end.
`timescale 1ns/1ps
`default_nettype none
module twt_checker #(
   parameter int unsigned WRC_CYCLES = 200
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe_n,
   // User side.
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic start_seen,
   input wire logic stop_seen,
   input wire logic bus_idle,
   input wire logic dir_read,
   input wire logic wr_req,
   input wire logic wr_busy
);
   import twt_pkg::*;
   int busy_cnt_ff;
   int low_cnt_ff;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy_cnt_ff <= 0;
         low_cnt_ff <= 0;
      end else begin
         busy_cnt_ff <= wr_busy ? busy_cnt_ff + 1 : 0;
         low_cnt_ff <= scl_in ? 0 : low_cnt_ff + 1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_idle_high: assert property ((scl_in && sda_in) [*3] |-> bus_idle)
      else $error("idle lines not flagged");
   a_idle_low: assert property (!scl_in [*3] |-> !bus_idle)
      else $error("idle flagged with clock low");
   a_start_cond: assert property (start_seen |-> scl_in && !sda_in)
      else $error("start without start levels");
   a_stop_cond: assert property (stop_seen |-> scl_in && sda_in)
      else $error("stop without stop levels");
   a_stop_release: assert property (stop_seen |=> sda_oe_n && !dir_read)
      else $error("stop did not release");
   a_start_abandon: assert property (start_seen |=> sda_oe_n && !dir_read)
      else $error("start kept direction");
   a_hold_delay: assert property ($changed(sda_oe_n) && !scl_in |-> low_cnt_ff >= HOLD_CYC)
      else $error("data changed inside hold");
   a_high_steady: assert property (scl_in && $past(scl_in, 3) && $changed(sda_oe_n) |-> sda_oe_n)
      else $error("data driven with clock high");
   a_busy_len: assert property ($fell(wr_busy) |-> busy_cnt_ff == WRC_CYCLES)
      else $error("write cycle length wrong");
   a_busy_start: assert property (wr_req && !wr_busy |=> wr_busy)
      else $error("write cycle not started");
   a_busy_no_ack: assert property (wr_busy && $fell(sda_oe_n) |-> dir_read)
      else $error("acknowledge during write cycle");
   a_rx_timing: assert property (rx_valid |-> !scl_in && $past(scl_in, 6))
      else $error("byte not tied to clock fall");
   a_dir_bit: assert property ($rose(dir_read) |-> rx_data[0])
      else $error("direction not from low bit");
endmodule // twt_checker
bind twt_target twt_checker #(.WRC_CYCLES(WRC_CYCLES)) i_chk (.clock(clock), .rst(rst),
   .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n), .rx_data(rx_data),
   .rx_valid(rx_valid), .start_seen(start_seen), .stop_seen(stop_seen),
   .bus_idle(bus_idle), .dir_read(dir_read), .wr_req(wr_req), .wr_busy(wr_busy));
`default_nettype wire

// ---- test/twt_ctrl_model.sv ----
// Bus controller model: makes the serial clock and pulls the data line low.
`timescale 1ns/1ps
`default_nettype none
module twt_ctrl_model (
   // Bus lines.
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   localparam int T_HI = 80;
   localparam int T_LO = 480;
   localparam int T_CND = 200;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // A start is opened from idle, or after raising a low clock.
   task automatic start();
      if (!scl) begin
         sda_low = 1'b0;
         #T_CND scl = 1'b1;
      end
      #T_CND sda_low = 1'b1;
      #T_CND scl = 1'b0;
   endtask
   task automatic stop();
      #20 sda_low = 1'b1;
      #T_CND scl = 1'b1;
      #T_CND sda_low = 1'b0;
      #T_CND;
   endtask
   // Data moves only with the clock low.
   task automatic pulse(input logic b, output logic s);
      #20 sda_low = !b;
      #(T_LO - 20) scl = 1'b1;
      #(T_HI / 2) s = sda;
      #(T_HI / 2) scl = 1'b0;
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) pulse(d[i], s);
      pulse(1'b1, ack);
   endtask
   task automatic rd_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
      pulse(nack, s);
   endtask
endmodule // twt_ctrl_model
`default_nettype wire
